// ---- dv/serial_flash_model.sv ----
// behavioural serial peripheral on the far side of the port
// assumes select active low; the bench names the sampling level and read lanes
`timescale 1ns/1ps
module serial_flash_model (
  input  wire logic        sclk_in,
  input  wire logic        sel_n_in,
  input  wire logic        smp_in,
  input  wire logic [3:0]  lanes_oe_in,
  input  wire logic [2:0]  rd_lanes_in,
  input  wire logic [3:0]  mosi_in,
  input  wire logic [15:0] resp_in,
  output logic      [3:0]  miso_out,
  output logic      [15:0] got_out
);
  logic [15:0] sh = 16'h0;
  logic [2:0]  ln;
  logic [3:0]  msk;
  assign ln  = lanes_oe_in == 4'hf ? 3'h4 : lanes_oe_in == 4'h3 ? 3'h2 :
               lanes_oe_in == 4'h1 ? 3'h1 : rd_lanes_in;
  assign msk = ln == 3'h4 ? 4'hf : ln == 3'h2 ? 4'h3 : 4'h1;
  function automatic logic [3:0] pick(input logic [15:0] s, input logic [2:0] l);
    pick = l == 3'h4 ? s[15:12] : l == 3'h2 ? {2'h0, s[15:14]} : {2'h0, s[15], 1'b0};
  endfunction
  // lanes follow the shifter at once; released lines show the inverse so a stale sample fails
  assign miso_out = sel_n_in ? ~pick(sh, ln) : pick(sh, ln);
  initial got_out = 16'h0;
  always @(negedge sel_n_in) begin
    sh = resp_in;
    got_out = 16'h0;
  end
  always @(sclk_in) begin
    if (!sel_n_in && sclk_in === smp_in)
      got_out = (got_out << ln) | {12'h0, mosi_in & msk};
    else if (!sel_n_in)
      sh = sh << ln;
  end
endmodule // serial_flash_model

// ---- dv/ssp_asserts.sv ----
// pin and bus timing checks for the serial port
// assumes it sees only the top module's ports and is attached by bind
`timescale 1ns/1ps
module ssp_asserts (
  input wire logic       clk_sys_in,
  input wire logic       rst_n_in,
  input wire logic       wb_cyc_in,
  input wire logic       wb_stb_in,
  input wire logic       wb_ack_out,
  input wire logic       sclk_oe_out,
  input wire logic       frame_select_line_out,
  input wire logic       frame_select_line_oe_out,
  input wire logic [3:0] sdata_oe_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);

  property p_ack_next;
    wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  property p_ack_pulse;
    wb_ack_out |=> !wb_ack_out;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_ack_cause;
    wb_ack_out |-> $past(wb_cyc_in && wb_stb_in);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_rst_vals;
    $rose(rst_n_in) |-> !wb_ack_out && frame_select_line_out && !sclk_oe_out
      && !frame_select_line_oe_out && sdata_oe_out == 4'h0;
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("pins not idle after reset");
  property p_lanes;
    sdata_oe_out inside {4'h0, 4'h1, 4'h3, 4'hf};
  endproperty
  a_lanes: assert property (p_lanes) else $error("bad lane enable set");
  property p_wide_master;
    |sdata_oe_out[3:1] |-> sclk_oe_out;
  endproperty
  a_wide_master: assert property (p_wide_master) else $error("wide lanes off master");
  property p_sel_oe;
    sclk_oe_out |-> frame_select_line_oe_out;
  endproperty
  a_sel_oe: assert property (p_sel_oe) else $error("master select not driven");
  property p_gap;
    sclk_oe_out && $rose(frame_select_line_out) |=> frame_select_line_out;
  endproperty
  a_gap: assert property (p_gap) else $error("select gap too short");
endmodule // ssp_asserts

bind sync_serial_adv_mode_config ssp_asserts chk_i (.clk_sys_in, .rst_n_in, .wb_cyc_in,
  .wb_stb_in, .wb_ack_out, .sclk_oe_out, .frame_select_line_out,
  .frame_select_line_oe_out, .sdata_oe_out);

// ---- dv/testbench.sv ----
// self-checking bench of the serial port against a peripheral model
// assumes a 25 MHz system clock and a free-running 320 ns oscillator
`timescale 1ns/1ps
`include "ssp_defs.vh"
module testbench;
  logic        clk_sys_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        osc = 1'b0;
  logic        wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
  logic [7:0]  wb_adr = 8'h0;
  logic [31:0] wb_dat = 32'h0;
  logic [31:0] wb_dat_out;
  logic        wb_ack_out, sclk_out, sclk_oe_out, frame_select_line_out, fs_oe;
  logic [3:0]  sdata_out, sdata_oe_out, miso;
  wire  [3:0]  sdata_bus;
  logic        tsclk = 1'b0, tsel = 1'b1, tgt = 1'b0, tdat = 1'b0, smp = 1'b1, fs_q = 1'b1;
  logic [2:0]  rdl = 3'h1;
  logic [15:0] resp = 16'h0, got;
  logic [3:0]  oe_acc = 4'h0;
  logic [19:0] words[$];
  int          failures = 0, compares = 0;
  always #20 clk_sys_in = ~clk_sys_in;
  always #160 osc = ~osc;
  assign sdata_bus = tgt ? {2'h0, tdat, 1'b0} : (sdata_out & sdata_oe_out) | (miso & ~sdata_oe_out);
  sync_serial_adv_mode_config uut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .wb_cyc_in(wb_cyc), .wb_stb_in(wb_stb), .wb_we_in(wb_we), .wb_adr_in(wb_adr),
    .wb_sel_in(4'hf), .wb_dat_in(wb_dat), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
    .osc_clk_in(osc), .sclk_in(tsclk), .sclk_out(sclk_out), .sclk_oe_out(sclk_oe_out),
    .frame_select_line_in(tsel), .frame_select_line_out(frame_select_line_out),
    .frame_select_line_oe_out(fs_oe), .sdata_in(sdata_bus), .sdata_out(sdata_out),
    .sdata_oe_out(sdata_oe_out));
  serial_flash_model far (.sclk_in(sclk_out), .sel_n_in(frame_select_line_out),
    .smp_in(smp), .lanes_oe_in(sdata_oe_out), .rd_lanes_in(rdl), .mosi_in(sdata_bus),
    .resp_in(resp), .miso_out(miso), .got_out(got));
  // one entry per frame: lanes driven and bits seen
  always @(posedge clk_sys_in) begin
    fs_q <= frame_select_line_out;
    oe_acc <= frame_select_line_out ? 4'h0 : oe_acc | sdata_oe_out;
    if (frame_select_line_out === 1'b1 && fs_q === 1'b0)
      words.push_back({oe_acc, got});
  end
  task automatic tally_and_finish;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_sys_in);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_dat <= d;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (wb_ack_out !== 1'b1 && n < 50);
    q = wb_dat_out;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    if (n >= 50)
      failures++;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0, q);
  endtask
  task automatic idle;
    logic [31:0] s;
    int n;
    n = 0;
    do begin
      rd(`REG_STAT, s);
      n++;
    end while (s[`STAT_BUSY] !== 1'b0 && n < 300);
    if (n >= 300)
      failures++;
    repeat (2) @(posedge clk_sys_in);
  endtask
  function automatic logic [31:0] cfg(input logic en, input logic [1:0] ro,
      input logic [2:0] f, input logic [4:0] w, input logic h, input logic s);
    cfg = {20'h0, s, h, 4'(w - 5'h1), f, ro, en};
  endfunction
  task automatic t_reset;
    logic [31:0] q;
    rd(`REG_CTRL, q);
    chk(q, 32'h1c0);
    rd(`REG_ADV, q);
    chk(q, 32'h0);
    rd(`REG_DIV, q);
    chk(q, 32'h1);
    rd(`REG_STAT, q);
    chk(q, 32'h4);
    wr(`REG_ADV, 32'h3);
    rd(`REG_ADV, q);
    chk(q, 32'h0);
    rd(8'h1c, q);
    chk(q, 32'h0);
    $display("done reset");
  endtask
  task automatic t_width;
    logic [31:0] q;
    wr(`REG_DIV, 32'h3);
    for (int k = 0; k < 2; k++) begin
      wr(`REG_CTRL, cfg(1'b1, 2'h0, 3'h0, k ? 5'd16 : 5'd4, 1'b0, 1'b0));
      resp = 16'hc3a5;
      words.delete();
      wr(`REG_DATA, 32'hfedcba96);
      rd(`REG_STAT, q);
      chk(q[`STAT_BUSY], 32'h1);
      idle();
      chk(words[0], k ? 20'h1ba96 : 20'h10006);
      rd(`REG_DATA, q);
      chk(q, k ? 32'hc3a5 : 32'hc);
    end
    $display("done width");
  endtask
  task automatic t_modes;
    logic [2:0]  md[7] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h1, 3'h5, 3'h6};
    logic [2:0]  rl[7] = '{3'h1, 3'h1, 3'h2, 3'h2, 3'h1, 3'h4, 3'h4};
    logic [3:0]  oe[7] = '{4'h1, 4'h1, 4'h0, 4'h3, 4'h1, 4'h0, 4'hf};
    logic [31:0] q;
    logic [7:0]  d, rb;
    logic        rdm;
    wr(`REG_CTRL, cfg(1'b1, 2'h0, 3'h0, 5'd8, 1'b0, 1'b0));
    foreach (md[i]) begin
      d = 8'h30 + 8'(i);
      rb = 8'hc0 + 8'(i);
      rdm = md[i] == 3'h3 || md[i] == 3'h5;
      resp = {rb, 8'h00};
      rdl = rl[i];
      words.delete();
      wr(`REG_ADV, {29'h0, md[i]});
      wr(`REG_DATA, {24'h0, d});
      idle();
      chk(words.size(), 32'h1);
      chk(words[0], {oe[i], 8'h00, rdm ? rb : d});
      rd(`REG_STAT, q);
      chk(q[`STAT_RX_AVAIL], rdm || md[i] == 3'h2);
      if (q[`STAT_RX_AVAIL] === 1'b1) begin
        rd(`REG_DATA, q);
        chk(q, {24'h0, rb});
      end
    end
    $display("done modes");
  endtask
  task automatic t_tag;
    wr(`REG_CTRL, cfg(1'b0, 2'h0, 3'h0, 5'd8, 1'b0, 1'b0));
    wr(`REG_ADV, 32'h6);
    wr(`REG_DATA, 32'h81);
    wr(`REG_ADV, 32'h1);
    wr(`REG_DATA, 32'h42);
    words.delete();
    wr(`REG_CTRL, cfg(1'b1, 2'h0, 3'h0, 5'd8, 1'b0, 1'b0));
    idle();
    chk(words.size(), 32'h2);
    chk(words[0], 20'hf0081);
    chk(words[1], 20'h10042);
    $display("done tag");
  endtask
  task automatic t_hold;
    wr(`REG_CTRL, cfg(1'b1, 2'h0, 3'h0, 5'd8, 1'b1, 1'b0));
    words.delete();
    wr(`REG_DATA, 32'h11);
    wr(`REG_DATA, 32'h22);
    idle();
    chk(frame_select_line_out, 32'h0);
    chk(words.size(), 32'h0);
    wr(`REG_DATA_EOF, 32'h33);
    idle();
    chk(words.size(), 32'h1);
    chk(words[0], 20'h12233);
    wr(`REG_CTRL, cfg(1'b1, 2'h0, 3'h0, 5'd8, 1'b0, 1'b0));
    wr(`REG_ADV, 32'h0);
    $display("done hold");
  endtask
  task automatic t_src;
    logic [31:0] q;
    wr(`REG_CTRL, cfg(1'b1, 2'h0, 3'h0, 5'd8, 1'b0, 1'b1));
    rd(`REG_CTRL, q);
    chk(q, cfg(1'b1, 2'h0, 3'h0, 5'd8, 1'b0, 1'b1));
    wr(`REG_DIV, 32'h0);
    words.delete();
    wr(`REG_DATA, 32'h96);
    idle();
    chk(words[0], 20'h10096);
    wr(`REG_CTRL, cfg(1'b1, 2'h0, 3'h0, 5'd8, 1'b0, 1'b0));
    wr(`REG_DIV, 32'h3);
    $display("done source");
  endtask
  task automatic t_fmt;
    for (int f = 0; f < 5; f++) begin
      wr(`REG_CTRL, cfg(1'b1, 2'h0, 3'(f), 5'd8, 1'b0, 1'b0));
      smp <= ~(f[1] ^ f[0]);
      repeat (4) @(posedge clk_sys_in);
      words.delete();
      wr(`REG_DATA, 32'ha6);
      idle();
      chk(words.size(), 32'h1);
      if (f < 4) begin
        chk(sclk_out, f[1]);
        chk(words[0], 20'h100a6);
      end else
        chk(frame_select_line_out, 32'h0);
    end
    $display("done formats");
  endtask
  task automatic t_target(input logic [1:0] ro);
    logic [31:0] q;
    logic [7:0]  tb;
    logic        seen;
    tb = 8'h96;
    seen = 1'b0;
    repeat (9) begin
      rd(`REG_STAT, q);
      if (q[`STAT_RX_AVAIL] === 1'b1)
        rd(`REG_DATA, q);
    end
    wr(`REG_CTRL, cfg(1'b1, ro, 3'h0, 5'd8, 1'b0, 1'b0));
    tgt <= 1'b1;
    tsel <= 1'b0;
    for (int i = 7; i >= 0; i--) begin
      tdat <= tb[i];
      repeat (6) @(posedge clk_sys_in);
      tsclk <= 1'b1;
      seen = seen | sdata_oe_out[0];
      repeat (6) @(posedge clk_sys_in);
      tsclk <= 1'b0;
    end
    repeat (6) @(posedge clk_sys_in);
    tsel <= 1'b1;
    tgt <= 1'b0;
    repeat (6) @(posedge clk_sys_in);
    rd(`REG_DATA, q);
    chk(q, 32'h96);
    chk(seen, ro == 2'h1);
    $display("done target");
  endtask
  initial begin
    repeat (10) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    t_reset();
    t_width();
    t_modes();
    t_tag();
    t_hold();
    t_src();
    t_fmt();
    t_target(2'h1);
    t_target(2'h2);
    tally_and_finish();
  end
  initial begin
    #1000000;
    failures++;
    tally_and_finish();
  end
endmodule // testbench

// ---- logic/ssp_defs.vh ----
// register map, field positions, reset values and codes of the serial port
// assumes a 32-bit classic bus slave with byte addresses, registers one word apart
`ifndef SSP_DEFS_VH
`define SSP_DEFS_VH
`define REG_CTRL       8'h00
`define REG_ADV        8'h04
`define REG_DIV        8'h08
`define REG_DATA       8'h0c
`define REG_DATA_EOF   8'h10
`define REG_STAT       8'h14
`define CTRL_EN        0
`define CTRL_ROLE_LSB  1
`define CTRL_FMT_LSB   3
`define CTRL_WID_LSB   6
`define CTRL_HOLD      10
`define CTRL_SRC       11
`define STAT_BUSY      0
`define STAT_TX_FULL   1
`define STAT_TX_EMPTY  2
`define STAT_RX_AVAIL  3
`define STAT_RX_FULL   4
`define RST_ROLE       2'h0
`define RST_FMT        3'h0
`define RST_WID        4'h7
`define RST_DIV        8'h01
`define WID_MIN        4'h3
`define MODE_COMPAT    3'h0
`define MODE_WR_ONLY   3'h1
`define MODE_FULL_ADV  3'h2
`define MODE_DUAL_RD   3'h3
`define MODE_DUAL_WR   3'h4
`define MODE_FOUR_RD   3'h5
`define MODE_FOUR_WR   3'h6
`define FMT_P0_PH0     3'h0
`define FMT_P0_PH1     3'h1
`define FMT_P1_PH0     3'h2
`define FMT_P1_PH1     3'h3
`define FMT_PULSE      3'h4
`define ROLE_MASTER    2'h0
`define ROLE_TARGET    2'h1
`define ROLE_TARGET_OFF 2'h2
`endif

// ---- logic/sync_serial_adv_mode_config.v ----
// synchronous serial port with advanced one, two and four lane modes
// assumes classic single-cycle bus masters; all pins are asynchronous to clk_sys_in
`timescale 1ns/1ps
`include "ssp_defs.vh"

module ssp_fifo #(
  parameter W  = 20,
  parameter D  = 8,
  parameter AW = 3
) (
  input  wire          clk_in,
  input  wire          rst_n_in,
  input  wire          push_in,
  input  wire          pop_in,
  input  wire [W-1:0]  din_in,
  output wire [W-1:0]  dout_out,
  output reg  [AW:0]   cnt_out
);
  reg [W-1:0]  mem [0:D-1];
  reg [AW-1:0] wp_r;
  reg [AW-1:0] rp_r;
  wire         do_push = push_in && (cnt_out != D[AW:0]);
  wire         do_pop  = pop_in && (cnt_out != {(AW+1){1'b0}});
  assign dout_out = mem[rp_r];
  always @(posedge clk_in) begin
    if (do_push) begin
      mem[wp_r] <= din_in;
    end
    if (!rst_n_in) begin
      wp_r    <= {AW{1'b0}};
      rp_r    <= {AW{1'b0}};
      cnt_out <= {(AW+1){1'b0}};
    end else begin
      if (do_push) begin
        wp_r <= (wp_r == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_r + 1'b1;
      end
      if (do_pop) begin
        rp_r <= (rp_r == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_r + 1'b1;
      end
      if (do_push && !do_pop) begin
        cnt_out <= cnt_out + 1'b1;
      end else if (do_pop && !do_push) begin
        cnt_out <= cnt_out - 1'b1;
      end
    end
  end
endmodule // ssp_fifo

module sync_serial_adv_mode_config #(
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire        clk_sys_in,
  input  wire        rst_n_in,
  input  wire        wb_cyc_in,
  input  wire        wb_stb_in,
  input  wire        wb_we_in,
  input  wire [7:0]  wb_adr_in,
  input  wire [3:0]  wb_sel_in,
  input  wire [31:0] wb_dat_in,
  output reg  [31:0] wb_dat_out,
  output reg         wb_ack_out,
  input  wire        osc_clk_in,
  input  wire        sclk_in,
  output reg         sclk_out,
  output reg         sclk_oe_out,
  input  wire        frame_select_line_in,
  output reg         frame_select_line_out,
  output reg         frame_select_line_oe_out,
  input  wire [3:0]  sdata_in,
  output reg  [3:0]  sdata_out,
  output reg  [3:0]  sdata_oe_out
);
  localparam S_IDLE  = 3'h0;
  localparam S_PULSE = 3'h1;
  localparam S_SHIFT = 3'h2;
  localparam S_GAP   = 3'h3;
  localparam S_WAIT  = 3'h4;

  function [2:0] lanes;
    input [2:0] m;
    begin
      if (m == `MODE_FOUR_RD || m == `MODE_FOUR_WR) lanes = 3'h4;
      else if (m == `MODE_DUAL_RD || m == `MODE_DUAL_WR) lanes = 3'h2;
      else lanes = 3'h1;
    end
  endfunction

  function receives;
    input [2:0] m;
    begin
      receives = !(m == `MODE_WR_ONLY || m == `MODE_DUAL_WR || m == `MODE_FOUR_WR);
    end
  endfunction

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  sel;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (sel[i]) merge[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
  endfunction

  // pins cross into clk_sys_in: bits 3:0 data, 4 sclk, 5 select, 6 oscillator
  reg [6:0] s1_r;
  reg [6:0] s2_r;
  reg [6:0] s3_r;
  always @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      // clock lanes reset to their idle low level so no false edge follows reset
      s1_r <= 7'h20;
      s2_r <= 7'h20;
      s3_r <= 7'h20;
    end else begin
      s1_r <= {osc_clk_in, frame_select_line_in, sclk_in, sdata_in};
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  wire [3:0] din_s = s2_r[3:0];
  wire       fs_s  = s2_r[5];

  reg        en_r;
  reg [1:0]  role_r;
  reg [2:0]  fmt_r;
  reg [3:0]  wid_r;
  reg        hold_r;
  reg        src_r;
  reg [2:0]  adv_r;
  reg [7:0]  div_r;
  reg [2:0]  st_r;
  reg        tx_push_r;
  reg [19:0] tx_din_r;
  reg        tx_pop_r;
  reg        rx_push_r;
  reg [15:0] rx_din_r;
  reg        rx_pop_r;
  wire [19:0] tx_dout;
  wire [15:0] rx_dout;
  wire [AW:0] tx_cnt;
  wire [AW:0] rx_cnt;

  ssp_fifo #(.W(20), .D(DEPTH), .AW(AW)) tx_q (
    .clk_in   (clk_sys_in),
    .rst_n_in (rst_n_in),
    .push_in  (tx_push_r),
    .pop_in   (tx_pop_r),
    .din_in   (tx_din_r),
    .dout_out (tx_dout),
    .cnt_out  (tx_cnt)
  );
  ssp_fifo #(.W(16), .D(DEPTH), .AW(AW)) rx_q (
    .clk_in   (clk_sys_in),
    .rst_n_in (rst_n_in),
    .push_in  (rx_push_r),
    .pop_in   (rx_pop_r),
    .din_in   (rx_din_r),
    .dout_out (rx_dout),
    .cnt_out  (rx_cnt)
  );

  wire        tx_empty = (tx_cnt == {(AW+1){1'b0}});
  wire        tx_full  = (tx_cnt == DEPTH[AW:0]);
  wire        busy     = !tx_empty || (st_r != S_IDLE && st_r != S_WAIT) || tx_pop_r;
  wire [15:0] wmask    = 16'hffff >> (4'hf - wid_r);
  wire [31:0] ctrl_rd  = {20'h0, src_r, hold_r, wid_r, fmt_r, role_r, en_r};
  wire [31:0] stat_rd  = {27'h0, rx_cnt == DEPTH[AW:0], rx_cnt != {(AW+1){1'b0}},
                          tx_empty, tx_full, busy};
  wire [31:0] ctrl_w   = merge(ctrl_rd, wb_dat_in, wb_sel_in);
  wire [31:0] adv_w    = merge({29'h0, adv_r}, wb_dat_in, wb_sel_in);
  wire [31:0] div_w    = merge({24'h0, div_r}, wb_dat_in, wb_sel_in);
  wire        req      = wb_cyc_in && wb_stb_in && !wb_ack_out;

  // bus slave: answers one edge after the request, unmapped reads give zero
  always @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0;
      en_r       <= 1'b0;
      role_r     <= `RST_ROLE;
      fmt_r      <= `RST_FMT;
      wid_r      <= `RST_WID;
      hold_r     <= 1'b0;
      src_r      <= 1'b0;
      adv_r      <= `MODE_COMPAT;
      div_r      <= `RST_DIV;
      tx_push_r  <= 1'b0;
      tx_din_r   <= 20'h0;
      rx_pop_r   <= 1'b0;
    end else begin
      wb_ack_out <= req;
      tx_push_r  <= 1'b0;
      rx_pop_r   <= 1'b0;
      if (req) begin
        wb_dat_out <= 32'h0;
        case (wb_adr_in)
          `REG_CTRL: begin
            wb_dat_out <= ctrl_rd;
            if (wb_we_in) begin
              en_r   <= ctrl_w[`CTRL_EN];
              role_r <= ctrl_w[`CTRL_ROLE_LSB +: 2];
              fmt_r  <= ctrl_w[`CTRL_FMT_LSB +: 3];
              wid_r  <= (ctrl_w[`CTRL_WID_LSB +: 4] < `WID_MIN) ? `WID_MIN :
                        ctrl_w[`CTRL_WID_LSB +: 4];
              hold_r <= ctrl_w[`CTRL_HOLD];
              src_r  <= ctrl_w[`CTRL_SRC];
            end
          end
          `REG_ADV: begin
            wb_dat_out <= {29'h0, adv_r};
            if (wb_we_in && adv_w[2:0] <= `MODE_FOUR_WR &&
                !(adv_r == `MODE_COMPAT && adv_w[2:0] >= `MODE_DUAL_RD)) begin
              adv_r <= adv_w[2:0];
            end
          end
          `REG_DIV: begin
            wb_dat_out <= {24'h0, div_r};
            if (wb_we_in) div_r <= div_w[7:0];
          end
          `REG_DATA, `REG_DATA_EOF: begin
            if (wb_we_in) begin
              // tag entry with mode; keep low width bits
              tx_push_r <= !tx_full;
              tx_din_r  <= {wb_adr_in == `REG_DATA_EOF, adv_r, wb_dat_in[15:0] & wmask};
            end else if (rx_cnt != {(AW+1){1'b0}}) begin
              wb_dat_out <= {16'h0, rx_dout};
              rx_pop_r   <= 1'b1;
            end
          end
          `REG_STAT: begin
            wb_dat_out <= stat_rd;
          end
          default: begin
            wb_dat_out <= 32'h0;
          end
        endcase
      end
    end
  end

  wire master = (role_r == `ROLE_MASTER);
  // polarity and phase from format; pulse format runs as phase one
  wire cpol   = (fmt_r == `FMT_P1_PH0) || (fmt_r == `FMT_P1_PH1);
  wire cpha   = (fmt_r == `FMT_P0_PH1) || (fmt_r == `FMT_P1_PH1) || (fmt_r == `FMT_PULSE);
  wire pulse  = (fmt_r == `FMT_PULSE);
  wire fs_off = !pulse;

  // baud ticks from system clock or the oscillator's rising edges
  reg  [7:0] bcnt_r;
  wire       btick = src_r ? (s2_r[6] && !s3_r[6]) : 1'b1;
  wire       half  = btick && (bcnt_r == div_r);
  always @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      bcnt_r <= 8'h0;
    end else if (st_r == S_IDLE || st_r == S_WAIT) begin
      // restart so the first half period is whole; returned data arrives late
      bcnt_r <= 8'h0;
    end else if (btick) begin
      bcnt_r <= half ? 8'h0 : bcnt_r + 8'h1;
    end
  end

  reg  [2:0]  mode_r;
  reg         eof_r;
  reg  [15:0] tx_r;
  reg  [15:0] rx_r;
  reg  [5:0]  hcnt_r;
  reg         sclk_r;
  reg         fs_r;
  wire [2:0]  lw    = lanes(mode_r);
  wire [4:0]  nb    = {1'b0, wid_r} + 5'h1;
  wire [4:0]  beats = (lw == 3'h4) ? (nb >> 2) : (lw == 3'h2) ? (nb >> 1) : nb;
  wire [5:0]  lastc = {beats, 1'b0} - 6'h1;
  wire        sev   = s2_r[4] != s3_r[4];
  wire        ev    = master ? half : sev;
  wire        lead  = master ? (sclk_r == cpol) : (s2_r[4] != cpol);
  // four lanes; two lanes; the single lane reads the receive line
  wire [3:0]  inb   = (lw == 3'h4) ? din_s : (lw == 3'h2) ? {2'h0, din_s[1:0]} :
                      {3'h0, din_s[1]};
  wire        adv_w_hold = hold_r && (mode_r != `MODE_COMPAT) && !eof_r;

  task load_word;
    begin
      if (!tx_empty) begin
        tx_r     <= tx_dout[15:0] << (4'hf - wid_r);
        mode_r   <= master ? tx_dout[18:16] : `MODE_COMPAT;
        eof_r    <= tx_dout[19];
        tx_pop_r <= 1'b1;
      end else begin
        tx_r   <= 16'h0;
        mode_r <= `MODE_COMPAT;
        eof_r  <= 1'b0;
      end
      rx_r   <= 16'h0;
      hcnt_r <= 6'h0;
    end
  endtask

  always @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      st_r      <= S_IDLE;
      mode_r    <= `MODE_COMPAT;
      eof_r     <= 1'b0;
      tx_r      <= 16'h0;
      rx_r      <= 16'h0;
      hcnt_r    <= 6'h0;
      sclk_r    <= 1'b0;
      fs_r      <= 1'b1;
      tx_pop_r  <= 1'b0;
      rx_push_r <= 1'b0;
      rx_din_r  <= 16'h0;
    end else begin
      tx_pop_r  <= 1'b0;
      rx_push_r <= 1'b0;
      if (!en_r) begin
        st_r   <= S_IDLE;
        sclk_r <= cpol;
        fs_r   <= fs_off;
      end else begin
        case (st_r)
          S_IDLE: begin
            sclk_r <= cpol;
            fs_r   <= fs_off;
            if (master && !tx_empty && !tx_pop_r) begin
              load_word;
              fs_r <= pulse;
              st_r <= pulse ? S_PULSE : S_SHIFT;
            end else if (!master && !fs_s) begin
              load_word;
              st_r <= S_SHIFT;
            end
          end
          S_PULSE: begin
            if (half) begin
              hcnt_r <= hcnt_r + 6'h1;
              if (hcnt_r == 6'h1) begin
                fs_r   <= 1'b0;
                hcnt_r <= 6'h0;
                st_r   <= S_SHIFT;
              end
            end
          end
          S_SHIFT: begin
            if (!master && fs_s) begin
              st_r <= S_IDLE;
            end else if (ev) begin
              if (master) sclk_r <= ~sclk_r;
              if (lead ^ cpha) begin
                rx_r <= (rx_r << lw) | {12'h0, inb};
              end else if (!(cpha && hcnt_r == 6'h0)) begin
                tx_r <= tx_r << lw;
              end
              hcnt_r <= hcnt_r + 6'h1;
              if (hcnt_r == lastc) begin
                // write-only modes drop received bits; full duplex keeps them
                rx_push_r <= receives(mode_r);
                rx_din_r  <= ((lead ^ cpha) ? ((rx_r << lw) | {12'h0, inb}) : rx_r) & wmask;
                hcnt_r    <= 6'h0;
                if (!master) begin
                  load_word;
                end else if (adv_w_hold) begin
                  // hold select between words; an end-of-frame word, a compatibility-mode word or clearing enable releases
                  if (!tx_empty && !tx_pop_r) load_word;
                  else st_r <= S_WAIT;
                end else begin
                  // release after end-of-frame; release after each word
                  st_r <= S_GAP;
                end
              end
            end
          end
          S_GAP: begin
            if (half) begin
              hcnt_r <= hcnt_r + 6'h1;
              // release half a period late so a trailing sample still sees select
              if (hcnt_r == 6'h0) fs_r <= fs_off;
              if (hcnt_r == 6'h2) begin
                hcnt_r <= 6'h0;
                st_r   <= S_IDLE;
              end
            end
          end
          S_WAIT: begin
            if (!tx_empty && !tx_pop_r) begin
              load_word;
              st_r <= S_SHIFT;
            end
          end
          default: begin
            st_r <= S_IDLE;
          end
        endcase
      end
    end
  end

  // pin stage; data, clock and select share this one-cycle delay so they stay aligned
  always @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      sclk_out                 <= 1'b0;
      sclk_oe_out              <= 1'b0;
      frame_select_line_out    <= 1'b1;
      frame_select_line_oe_out <= 1'b0;
      sdata_out                <= 4'h0;
      sdata_oe_out             <= 4'h0;
    end else begin
      sclk_out                 <= sclk_r;
      sclk_oe_out              <= en_r && master;
      frame_select_line_out    <= fs_r;
      frame_select_line_oe_out <= en_r && master;
      // wide modes turn lanes toward the transfer direction
      if (lw == 3'h4) begin
        sdata_out    <= tx_r[15:12];
        sdata_oe_out <= (mode_r == `MODE_FOUR_WR && st_r != S_IDLE) ? 4'hf : 4'h0;
      end else if (lw == 3'h2) begin
        sdata_out    <= {2'h0, tx_r[15:14]};
        sdata_oe_out <= (mode_r == `MODE_DUAL_WR && st_r != S_IDLE) ? 4'h3 : 4'h0;
      end else begin
        sdata_out    <= {3'h0, tx_r[15]};
        // target with output off never drives its transmit line
        sdata_oe_out <= {3'h0, en_r && (master || (role_r == `ROLE_TARGET && !fs_s))};
      end
    end
  end
endmodule // sync_serial_adv_mode_config
